// [bench/snoop_inquire_backoff_unit_tb.sv]
/*
 * Self-checking bench of the snoop and backoff unit: random snoops under address hold
 * and under backoff. Assumes the bus model answers every cycle and the cache answers
 * lookups in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module snoop_inquire_backoff_unit_tb;
    import snoop_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, addr_float_request_in = 1'b0;
    logic bus_abort_request_n_in = 1'b1, ext_addr_strobe_n_in = 1'b1, snoop_invalidate_in = 1'b0;
    logic transfer_ready_n_in, cacheable_input_n_in = 1'b0, req_valid_in = 1'b0;
    logic req_write_in = 1'b0, req_burst_in = 1'b0, lookup_found_in = 1'b0;
    logic lookup_modified_in = 1'b0, addr_oe_n_out, cycle_addr_strobe_n_out, ctrl_oe_n_out;
    logic data_oe_n_out, snoop_hit_n_out, snoop_dirty_n_out, req_ready_out, done_out;
    logic rdata_valid_out, rdata_cacheable_out, lookup_valid_out, update_valid_out;
    logic update_invalidate_out, exp_inv = 1'b0, last_hit_n = 1'b1, write_cycle_out;
    bus_addr_t   addr_in = '0, addr_out, req_addr_in = '0;
    line_addr_t  lookup_addr_out;
    logic [63:0] data_in, req_wdata_in = 64'h0, wb_data_in, data_out, rdata_out;
    logic [1:0]  wb_beat_out;
    logic [3:0]  stall = 4'h0;
    logic [2:0]  beats = 3'h1, rd_k = 3'h0;
    logic [31:0] seed = 32'hc149cf4a;
    int          num_errors = 0, compares = 0, cycles = 0, upd_cnt = 0, rd_cnt = 0;

    snoop_inquire_backoff_unit i_snoop_inquire_backoff_unit (.clk_in, .rst_n_in,
        .addr_float_request_in, .bus_abort_request_n_in, .ext_addr_strobe_n_in,
        .snoop_invalidate_in, .transfer_ready_n_in, .cacheable_input_n_in, .addr_in, .addr_out,
        .addr_parity_out(), .addr_oe_n_out, .cycle_addr_strobe_n_out, .write_cycle_out,
        .ctrl_oe_n_out, .data_in, .data_out, .data_parity_out(), .data_oe_n_out,
        .snoop_hit_n_out, .snoop_dirty_n_out, .req_valid_in, .req_addr_in, .req_write_in,
        .req_burst_in, .req_wdata_in, .req_ready_out, .done_out, .rdata_out,
        .rdata_valid_out, .rdata_cacheable_out, .lookup_valid_out, .lookup_addr_out,
        .lookup_found_in, .lookup_modified_in, .update_valid_out, .update_invalidate_out,
        .wb_beat_out, .wb_data_in);
    sys_bus_model i_sys_bus_model (.clk_in, .rst_n_in,
        .cycle_addr_strobe_n_in(cycle_addr_strobe_n_out),
        .transfer_ready_n_out(transfer_ready_n_in), .data_out(data_in),
        .stall_in(stall), .beats_in(beats));

    ////////////////////////////////////////////////////////////////////////////////
    assign wb_data_in = {62'h0, wb_beat_out};
    always #5 clk_in = ~clk_in;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // The ceiling is far above the few hundred cycles that the scenarios need.
    always @(posedge clk_in) begin
        cycles++;
        if (rst_n_in && update_valid_out) upd_cnt++;
        if (rst_n_in && update_valid_out) chk(update_invalidate_out, exp_inv);
        if (rdata_valid_out) rd_cnt++;
        if (rdata_valid_out) begin
            chk(rdata_out, {16{1'b0, beats - rd_k}});
            rd_k = done_out ? 3'h0 : rd_k + 3'h1;
        end
        if (req_valid_in && req_ready_out) req_valid_in <= 1'b0;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic snoop(input line_addr_t a, input logic i, input logic f, input logic m,
                         input logic rel);
        chk(snoop_hit_n_out, last_hit_n);
        @(posedge clk_in);
        ext_addr_strobe_n_in <= 1'b0;
        addr_in <= {a, LINE_OFS};
        snoop_invalidate_in <= i;
        lookup_found_in <= f;
        lookup_modified_in <= m;
        exp_inv = i;
        @(posedge clk_in);
        ext_addr_strobe_n_in <= 1'b1;
        addr_in <= ~{a, LINE_OFS};
        if (rel) addr_float_request_in <= 1'b0;
        @(posedge clk_in iff lookup_valid_out);
        chk(lookup_addr_out, a);
        #1;
        chk(snoop_hit_n_out, !f);
        chk(snoop_dirty_n_out, !(f && m));
        last_hit_n = !f;
    endtask

    task automatic bus_cycle(input bus_addr_t a, input logic flt, input logic [2:0] n,
                             input logic [3:0] s, input logic w);
        beats <= n;
        stall <= s;
        @(posedge clk_in iff !cycle_addr_strobe_n_out);
        chk(addr_oe_n_out, flt);
        if (!flt) chk(addr_out, a);
        chk(write_cycle_out, w);
    endtask

    task automatic hold_case(input logic f, input logic m, input logic keep);
        logic [31:0] x;
        int          u;
        x = rnd();
        u = upd_cnt;
        @(posedge clk_in);
        addr_float_request_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        req_addr_in <= x[31:3];
        req_burst_in <= x[0];
        req_write_in <= x[4] && !x[0];
        req_wdata_in <= {x, ~x};
        req_valid_in <= 1'b1;
        #1;
        chk({addr_oe_n_out, ctrl_oe_n_out}, 2'h2);
        snoop(x[31:5], x[1], f, m, !keep);
        if (m) begin
            bus_cycle({x[31:5], LINE_OFS}, keep, 3'h4, x[3:2], 1'b1);
            chk(upd_cnt, u);
            @(posedge clk_in iff snoop_dirty_n_out);
        end
        addr_float_request_in <= 1'b0;
        bus_cycle(x[31:3], 1'b0, x[0] ? 3'h4 : 3'h1, x[3:2], x[4] && !x[0]);
        if (x[4] && !x[0]) chk(data_out, {x, ~x});
        @(posedge clk_in iff done_out);
        chk(upd_cnt, u + int'(f));
    endtask

    task automatic bus_abort_request_n_case(input logic m);
        logic [31:0] x;
        int          n;
        x = rnd();
        @(posedge clk_in);
        req_addr_in <= x[31:3];
        req_burst_in <= 1'b1;
        req_write_in <= 1'b0;
        req_valid_in <= 1'b1;
        bus_cycle(x[31:3], 1'b0, 3'h4, x[3:2], 1'b0);
        repeat (x[3:2]) @(posedge clk_in);
        bus_abort_request_n_in <= 1'b0;
        n = rd_cnt;
        repeat (4) @(posedge clk_in);
        #1;
        chk({addr_oe_n_out, ctrl_oe_n_out, data_oe_n_out}, 3'h7);
        chk(rd_cnt, n);
        snoop(x[31:5], x[4], 1'b1, m, 1'b0);
        bus_abort_request_n_in <= 1'b1;
        if (m) begin
            bus_cycle({x[31:5], LINE_OFS}, 1'b0, 3'h4, x[3:2], 1'b1);
            @(posedge clk_in iff snoop_dirty_n_out);
        end
        // The restarted read sees the same cacheable level as the aborted one.
        bus_cycle(x[31:3], 1'b0, 3'h4, x[3:2], 1'b0);
        @(posedge clk_in iff done_out);
        #1;
        chk(rd_cnt, n + 4);
        chk(rdata_cacheable_out, !cacheable_input_n_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cacheable_input_n_in = seed[0];
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk({addr_oe_n_out, cycle_addr_strobe_n_out, snoop_hit_n_out, snoop_dirty_n_out,
             data_oe_n_out}, 5'h0f);
        for (int k = 0; k < 6; k++) begin
            hold_case(k != 3, (k % 3) != 0, (k % 3) != 1);
            bus_abort_request_n_case(k[0]);
        end
        conclude();
    end
endmodule
`default_nettype wire

// [bench/sys_bus_model.sv]
/*
 * System-side bus model: answers each cycle strobe with ready beats after a stall.
 * Assumes the unit's cycle strobe is a one-cycle pulse launched from a flop.
 */
`timescale 1ns/100ps
`default_nettype none
module sys_bus_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Bus side
    input  wire logic        cycle_addr_strobe_n_in,
    output logic             transfer_ready_n_out,
    output logic [63:0]      data_out,
    // Pacing set by the bench
    input  wire logic [3:0]  stall_in,
    input  wire logic [2:0]  beats_in
);
    logic [3:0]  wait_ff = 4'h0;
    logic [2:0]  left_ff = 3'h0;
    logic [63:0] last_ff = 64'h0;
    logic        beat;

    ////////////////////////////////////////////////////////////////////////////////
    assign beat = (wait_ff == 4'h0) && (left_ff != 3'h0);
    assign transfer_ready_n_out = !beat;
    // Between beats the data lines are not held, so they flip rather than keep a stale value.
    assign data_out = beat ? {16{1'b0, left_ff}} : ~last_ff;

    always @(posedge clk_in) begin
        last_ff <= data_out;
        if (!rst_n_in) begin
            wait_ff <= 4'h0;
            left_ff <= 3'h0;
        end else if (!cycle_addr_strobe_n_in) begin
            wait_ff <= stall_in;
            left_ff <= beats_in;
        end else if (wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (left_ff != 3'h0) begin
            left_ff <= left_ff - 3'h1;
        end
    end
endmodule
`default_nettype wire

// [hw/snoop_if.sv]
/*
 * Carrier between the bus sequencer and the snoop responder.
 * Assumes both ends run on the bus clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface snoop_if;
    import snoop_pkg::*;
    logic       ext_addr_strobe_n;
    logic       snoop_invalidate;
    line_addr_t addr;
    logic       lk_valid;
    logic       lk_found;
    logic       lk_mod;
    logic       upd_valid;
    logic       upd_inv;
    logic       hit_n;
    logic       dirty_n;
    logic       wb_req;
    line_addr_t wb_addr;
    logic       wb_done;

    modport seq (output ext_addr_strobe_n, snoop_invalidate, addr, lk_found, lk_mod, wb_done,
                 input lk_valid, upd_valid, upd_inv, hit_n, dirty_n, wb_req, wb_addr);
    modport probe (input ext_addr_strobe_n, snoop_invalidate, addr, lk_found, lk_mod, wb_done,
                   output lk_valid, upd_valid, upd_inv, hit_n, dirty_n, wb_req, wb_addr);
endinterface
`default_nettype wire

// [hw/snoop_inquire_backoff_unit.sv]
/*
 * Bus-side snoop and backoff unit: runs core and writeback bus cycles,
 * floats the address bus under address hold, aborts and restarts on backoff.
 * Assumes core and cache ports are on clk_in and bus pins are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none
module snoop_inquire_backoff_unit (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    // Bus control pins
    input  wire logic                    addr_float_request_in,
    input  wire logic                    bus_abort_request_n_in,
    input  wire logic                    ext_addr_strobe_n_in,
    input  wire logic                    snoop_invalidate_in,
    input  wire logic                    transfer_ready_n_in,
    input  wire logic                    cacheable_input_n_in,
    // Address pins
    input  wire snoop_pkg::bus_addr_t    addr_in,
    output var snoop_pkg::bus_addr_t     addr_out,
    output logic                         addr_parity_out,
    output logic                         addr_oe_n_out,
    // Cycle control pins
    output logic                         cycle_addr_strobe_n_out,
    output logic                         write_cycle_out,
    output logic                         ctrl_oe_n_out,
    // Data pins
    input  wire logic [63:0]             data_in,
    output logic [63:0]                  data_out,
    output logic [7:0]                   data_parity_out,
    output logic                         data_oe_n_out,
    // Snoop result pins
    output logic                         snoop_hit_n_out,
    output logic                         snoop_dirty_n_out,
    // Core request port
    input  wire logic                    req_valid_in,
    input  wire snoop_pkg::bus_addr_t    req_addr_in,
    input  wire logic                    req_write_in,
    input  wire logic                    req_burst_in,
    input  wire logic [63:0]             req_wdata_in,
    output logic                         req_ready_out,
    output logic                         done_out,
    output logic [63:0]                  rdata_out,
    output logic                         rdata_valid_out,
    output logic                         rdata_cacheable_out,
    // Cache port
    output logic                         lookup_valid_out,
    output var snoop_pkg::line_addr_t    lookup_addr_out,
    input  wire logic                    lookup_found_in,
    input  wire logic                    lookup_modified_in,
    output logic                         update_valid_out,
    output logic                         update_invalidate_out,
    output logic [1:0]                   wb_beat_out,
    input  wire logic [63:0]             wb_data_in
);
    import snoop_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: only the second stage is read.

    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;
    wire  [SYNC_W-1:0] pins_raw;

    assign pins_raw = {addr_float_request_in, bus_abort_request_n_in, ext_addr_strobe_n_in,
                       snoop_invalidate_in, transfer_ready_n_in, cacheable_input_n_in,
                       addr_in, data_in};

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_ff <= SYNC_IDLE;
            sync_ff <= SYNC_IDLE;
        end else begin
            meta_ff <= pins_raw;
            sync_ff <= meta_ff;
        end
    end

    wire              addr_float_request_s;
    wire              bus_abort_request_n_n_s;
    wire              ext_addr_strobe_n_n_s;
    wire              inv_s;
    wire              transfer_ready_n_n_s;
    wire              ken_n_s;
    wire bus_addr_t   addr_s;
    wire [DATA_W-1:0] data_s;

    assign {addr_float_request_s, bus_abort_request_n_n_s, ext_addr_strobe_n_n_s, inv_s, transfer_ready_n_n_s, ken_n_s, addr_s, data_s} = sync_ff;

    wire bus_abort_request_n_s = ~bus_abort_request_n_n_s;
    wire transfer_ready_n_s = ~transfer_ready_n_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Snoop responder.

    snoop_if sn ();

    assign sn.ext_addr_strobe_n     = ~ext_addr_strobe_n_n_s;
    assign sn.snoop_invalidate      = inv_s;
    assign sn.addr     = addr_s[ADDR_HI:LINE_LO];
    assign sn.lk_found = lookup_found_in;
    assign sn.lk_mod   = lookup_modified_in;

    snoop_probe u_probe (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .sn       (sn)
    );

    assign lookup_valid_out      = sn.lk_valid;
    assign lookup_addr_out       = sn.addr;
    assign update_valid_out      = sn.upd_valid;
    assign update_invalidate_out = sn.upd_inv;
    assign snoop_hit_n_out       = sn.hit_n;
    assign snoop_dirty_n_out     = sn.dirty_n;

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer.

    bus_state_e        state_ff;
    logic              src_wb_ff;
    logic              burst_ff;
    logic              write_ff;
    logic              restart_ff;
    logic [BEAT_W-1:0] beat_ff;
    bus_addr_t         cur_addr_ff;
    logic [DATA_W-1:0] cur_wdata_ff;
    logic              cur_write_ff;
    bus_addr_t         addr_ff;
    logic [DATA_W-1:0] data_ff;
    logic              done_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              rvalid_ff;
    logic              ken_ff;

    bus_state_e        nxt_state;
    logic [BEAT_W-1:0] nxt_beat;

    // A cycle launches from idle or straight out of bus hold on its release edge.
    wire can_launch = (state_ff == ST_IDLE || state_ff == ST_BUS_ABORT_REQUEST_N) && !bus_abort_request_n_s;
    wire launch_wb  = can_launch && sn.wb_req;
    wire launch_rs  = can_launch && !sn.wb_req && restart_ff && !addr_float_request_s;
    wire take_req   = can_launch && !sn.wb_req && !restart_ff && !addr_float_request_s && req_valid_in;
    wire launch     = launch_wb || launch_rs || take_req;
    wire in_cycle   = state_ff == ST_ADDR || state_ff == ST_DATA;
    wire last_beat  = (src_wb_ff || burst_ff) ? (beat_ff == BEAT_LAST) : 1'b1;
    wire beat_done  = state_ff == ST_DATA && transfer_ready_n_s && !bus_abort_request_n_s;
    wire cyc_end    = beat_done && last_beat;
    wire bus_float  = state_ff == ST_BUS_ABORT_REQUEST_N;

    assign req_ready_out = take_req;
    assign sn.wb_done    = cyc_end && src_wb_ff;
    assign wb_beat_out   = nxt_beat;

    always_comb begin
        nxt_state = state_ff;
        nxt_beat  = beat_ff;
        if (bus_abort_request_n_s) begin
            nxt_state = ST_BUS_ABORT_REQUEST_N;
        end else if (launch) begin
            nxt_state = ST_ADDR;
            nxt_beat  = BEAT_FIRST;
        end else if (state_ff == ST_ADDR) begin
            nxt_state = ST_DATA;
        end else if (cyc_end) begin
            nxt_state = ST_IDLE;
        end else if (beat_done) begin
            nxt_beat  = beat_ff + 2'h1;
        end else if (state_ff == ST_BUS_ABORT_REQUEST_N) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_IDLE;
            beat_ff  <= BEAT_FIRST;
        end else begin
            state_ff <= nxt_state;
            beat_ff  <= nxt_beat;
        end
    end

    // Cycle that an abort would have to repeat.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            restart_ff   <= 1'b0;
            cur_addr_ff  <= '0;
            cur_wdata_ff <= '0;
            cur_write_ff <= 1'b0;
        end else if (take_req) begin
            cur_addr_ff  <= req_addr_in;
            cur_wdata_ff <= req_wdata_in;
            cur_write_ff <= req_write_in;
        end else if (bus_abort_request_n_s && in_cycle && !src_wb_ff) begin
            restart_ff   <= 1'b1;
        end else if (launch_rs) begin
            restart_ff   <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            src_wb_ff <= 1'b0;
            burst_ff  <= 1'b0;
            write_ff  <= 1'b0;
        end else if (launch) begin
            src_wb_ff <= launch_wb;
            burst_ff  <= take_req ? req_burst_in && !req_write_in : burst_ff;
            write_ff  <= launch_wb || (take_req ? req_write_in : cur_write_ff);
        end
    end

    // Writeback drives the captured line address with zero offset.
    wire bus_addr_t nxt_addr = launch_wb ? {sn.wb_addr, LINE_OFS} :
                               take_req  ? req_addr_in : cur_addr_ff;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_ff <= '0;
            data_ff <= '0;
        end else begin
            addr_ff <= launch ? nxt_addr : addr_ff;
            data_ff <= (launch_wb || (src_wb_ff && in_cycle)) ? wb_data_in :
                       take_req ? req_wdata_in : launch_rs ? cur_wdata_ff : data_ff;
        end
    end

    // Read results back to the core.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            done_ff   <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            ken_ff    <= 1'b0;
        end else begin
            done_ff   <= cyc_end && !src_wb_ff;
            rvalid_ff <= beat_done && !write_ff;
            rdata_ff  <= (beat_done && !write_ff) ? data_s : rdata_ff;
            ken_ff    <= (beat_done && !write_ff) ? ~ken_n_s : ken_ff;
        end
    end

    assign done_out            = done_ff;
    assign rdata_valid_out     = rvalid_ff;
    assign rdata_out           = rdata_ff;
    assign rdata_cacheable_out = ken_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive. Address hold floats only the address and its parity;
    // this keeps an in-flight cycle running while the system snoops.

    assign addr_out                = addr_ff;
    assign addr_parity_out         = ^addr_ff;
    assign addr_oe_n_out           = addr_float_request_s || bus_float;
    assign cycle_addr_strobe_n_out = state_ff != ST_ADDR;
    assign write_cycle_out         = write_ff;
    assign ctrl_oe_n_out           = bus_float;
    assign data_out                = data_ff;
    assign data_parity_out         = lane_parity(data_ff);
    assign data_oe_n_out           = !(in_cycle && write_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_release_idle;
        state_ff == ST_IDLE && !addr_float_request_s && !bus_abort_request_n_s && !sn.wb_req && !restart_ff;
    endsequence

    sequence s_backoff_over;
        state_ff == ST_BUS_ABORT_REQUEST_N && !bus_abort_request_n_s && !addr_float_request_s && !sn.wb_req && restart_ff;
    endsequence

    sequence s_strobe_cycle;
        state_ff == ST_ADDR ##1 state_ff == ST_DATA;
    endsequence

    a_new_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_release_idle ##0 req_valid_in |=> s_strobe_cycle)
        else $error("cycle not started on release");
    a_restart_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        s_backoff_over |=> s_strobe_cycle ##0 addr_ff == cur_addr_ff)
        else $error("aborted cycle not restarted");
    a_backoff_abort: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        bus_abort_request_n_s |=> state_ff == ST_BUS_ABORT_REQUEST_N && cycle_addr_strobe_n_out)
        else $error("backoff did not abort");
    a_ready_lost: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_ff == ST_DATA && transfer_ready_n_s && bus_abort_request_n_s && !src_wb_ff |=> restart_ff && !done_ff)
        else $error("backoff did not beat ready");
    a_wb_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        can_launch && sn.wb_req |=> state_ff == ST_ADDR && src_wb_ff && write_ff)
        else $error("cycle started before writeback");
    a_wb_address: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_ff == ST_ADDR && src_wb_ff |-> addr_ff[ADDR_HI:LINE_LO] == sn.wb_addr)
        else $error("writeback address wrong");
    a_addr_float: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        addr_float_request_s |-> addr_oe_n_out && (ctrl_oe_n_out == bus_float))
        else $error("address hold float wrong");
    a_addr_back: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !addr_float_request_s && state_ff != ST_BUS_ABORT_REQUEST_N |-> !addr_oe_n_out)
        else $error("address drivers not back");
    a_all_float: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        state_ff == ST_BUS_ABORT_REQUEST_N |-> addr_oe_n_out && ctrl_oe_n_out && data_oe_n_out)
        else $error("outputs driven in bus hold");
    a_dirty_wb: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(sn.wb_req) && can_launch |=> state_ff == ST_ADDR)
        else $error("writeback not immediate");
endmodule
`default_nettype wire

// [hw/snoop_pkg.sv]
/*
 * Shared constants and types for the snoop and backoff unit.
 * Assumes a single bus clock and a cache that answers tag lookups in the same cycle.
 */
`default_nettype none
package snoop_pkg;
    // Address bus field positions, data width, byte lanes and beat counter width.
    localparam int ADDR_HI  = 31;
    localparam int ADDR_LO  = 3;
    localparam int LINE_LO  = 5;
    localparam int DATA_W   = 64;
    localparam int BYTES    = 8;
    localparam int BEAT_W   = 2;

    // Negated levels of the active-low outputs at reset.
    localparam logic PIN_NEG = 1'b1;
    localparam int SYNC_W   = 6 + (ADDR_HI - ADDR_LO + 1) + DATA_W;

    // Idle levels of the synchronised pins, so reset shows no false strobe or backoff.
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b0, PIN_NEG, PIN_NEG, 1'b0, PIN_NEG, PIN_NEG,
                                               {(SYNC_W-6){1'b0}}};

    // Numbers of the first and the last beat of a line burst.
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_LAST  = 2'h3;

    // Offset bits inside a line that a writeback drives as zero.
    localparam logic [LINE_LO-ADDR_LO-1:0] LINE_OFS = 2'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_BUS_ABORT_REQUEST_N} bus_state_e;

    typedef logic [ADDR_HI:LINE_LO] line_addr_t;
    typedef logic [ADDR_HI:ADDR_LO] bus_addr_t;

    // Even parity per byte lane.
    function automatic logic [BYTES-1:0] lane_parity(input logic [DATA_W-1:0] d);
        logic [BYTES-1:0] p;
        p = '0;
        for (int i = 0; i < BYTES; i++) begin
            p[i] = ^d[i*8 +: 8];
        end
        return p;
    endfunction
endpackage
`default_nettype wire

// [hw/snoop_probe.sv]
/*
 * Snoop responder: looks up inquire addresses, drives the hit pins and
 * orders the line state change behind any writeback.
 * Assumes ext_addr_strobe_n is a synchronised one-cycle sample of the external strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module snoop_probe
    import snoop_pkg::*;
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // Sequencer side
    snoop_if.probe    sn
);
    logic       hit_n_ff;
    logic       dirty_n_ff;
    logic       wb_req_ff;
    logic       pend_inv_ff;
    line_addr_t wb_addr_ff;
    wire        dirty_hit;

    // A pending writeback blocks further lookups so the line is not lost.
    assign sn.lk_valid  = sn.ext_addr_strobe_n & ~wb_req_ff;
    assign dirty_hit    = sn.lk_valid & sn.lk_found & sn.lk_mod;
    assign sn.upd_valid = (sn.lk_valid & sn.lk_found & ~sn.lk_mod) | sn.wb_done;
    assign sn.upd_inv   = sn.wb_done ? pend_inv_ff : sn.snoop_invalidate;
    assign sn.hit_n     = hit_n_ff;
    assign sn.dirty_n   = dirty_n_ff;
    assign sn.wb_req    = wb_req_ff;
    assign sn.wb_addr   = wb_addr_ff;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hit_n_ff    <= PIN_NEG;
            dirty_n_ff  <= PIN_NEG;
            wb_req_ff   <= 1'b0;
            pend_inv_ff <= 1'b0;
            wb_addr_ff  <= '0;
        end else if (sn.lk_valid) begin
            hit_n_ff    <= ~sn.lk_found;
            dirty_n_ff  <= ~dirty_hit;
            wb_req_ff   <= dirty_hit;
            pend_inv_ff <= sn.snoop_invalidate;
            wb_addr_ff  <= sn.addr;
        end else if (sn.wb_done) begin
            dirty_n_ff  <= PIN_NEG;
            wb_req_ff   <= 1'b0;
        end
    end

    a_clean_hit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sn.lk_valid && sn.lk_found && !sn.lk_mod |=> !sn.hit_n && sn.dirty_n)
        else $error("clean hit not reported");
    a_dirty_hit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        dirty_hit |=> !sn.hit_n && !sn.dirty_n && sn.wb_req)
        else $error("dirty hit not reported");
    a_hit_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !sn.lk_valid |=> $stable(sn.hit_n))
        else $error("hit level changed without inquire");
    a_dirty_implies: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !sn.dirty_n |-> !sn.hit_n)
        else $error("dirty without hit");
    a_state_late: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        dirty_hit |-> !sn.upd_valid)
        else $error("state changed before writeback");
endmodule
`default_nettype wire
